// ===== uaar_cfg.svh
/*
  Register indices, byte addresses, bit positions, reset values and
  bit-period counts of the serial port with address recognition.
  Assumes a 12-bit APB byte address, one 32-bit word per register.
*/
`ifndef UAAR_CFG_SVH
`define UAAR_CFG_SVH

// ---------------------------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------------------------
`define UAAR_IDX_PWR 8'h87
`define UAAR_IDX_CTRL 8'h98
`define UAAR_IDX_DATA 8'h99
`define UAAR_IDX_BAUD 8'h9A
`define UAAR_IDX_ID 8'hA9
`define UAAR_IDX_MASK 8'hB9
`define UAAR_ADDR_PWR 12'(4 * `UAAR_IDX_PWR)
`define UAAR_ADDR_CTRL 12'(4 * `UAAR_IDX_CTRL)
`define UAAR_ADDR_DATA 12'(4 * `UAAR_IDX_DATA)
`define UAAR_ADDR_BAUD 12'(4 * `UAAR_IDX_BAUD)
`define UAAR_ADDR_ID 12'(4 * `UAAR_IDX_ID)
`define UAAR_ADDR_MASK 12'(4 * `UAAR_IDX_MASK)

// ---------------------------------------------------------------
// Serial control and power control bit positions
// ---------------------------------------------------------------
`define UAAR_B_MHI 7
`define UAAR_B_MLO 6
`define UAAR_B_MPE 5
`define UAAR_B_REN 4
`define UAAR_B_TB8 3
`define UAAR_B_RB8 2
`define UAAR_B_TI 1
`define UAAR_B_RI 0
`define UAAR_B_DBL 7
`define UAAR_B_B7SEL 6

// ---------------------------------------------------------------
// Reset values and port modes
// ---------------------------------------------------------------
`define UAAR_RST_CTRL 8'h00
`define UAAR_RST_ID 8'h00
`define UAAR_RST_MASK 8'h00
`define UAAR_RST_BAUD 16'h01B2
`define UAAR_MODE_SHIFT 2'h0
`define UAAR_MODE_VAR8 2'h1
`define UAAR_MODE_FIX9 2'h2
`define UAAR_MODE_VAR9 2'h3

// ---------------------------------------------------------------
// Bit periods in clock cycles
// ---------------------------------------------------------------
`define UAAR_M0_BIT 16'h000C
`define UAAR_M2_STD 16'h0040
`define UAAR_M2_DBL 16'h0020

`endif

// ===== uaar_pkg.sv
/*
  State types of the serial port with address recognition.
  Assumes nothing of its surroundings.
*/
package uaar_pkg;

  // -------------------------------------------------------------
  // Engine states
  // -------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_SEND} uaar_tx_st_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} uaar_rx_st_type;

endpackage

// ===== uaar_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module uaar_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } uaar_fifo_st_type;

  uaar_fifo_st_type s_r;
  uaar_fifo_st_type s_nxt;
  logic push;
  logic pop;

  assign in_ready = s_r.cnt != (AW + 1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // uaar_fifo

// ===== uaar_top.sv
/*
  Serial port with automatic slave address recognition, APB slave.
  Transmit bytes queue in a FIFO; a full FIFO stalls the APB write.
  Assumes pclk is the oscillator of the fixed-rate mode and that rxd
  comes from a pin outside the clock domain.
*/

`timescale 1ns/1ps
`include "uaar_cfg.svh"
module uaar_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  output logic shift_clk
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic fe;
    logic [7:0] slave_id;
    logic [7:0] slave_mask;
    logic baud_doubler;
    logic bit7_select;
    logic [DIV_W-1:0] baud;
    logic [31:0] rdata;
    logic [2:0] rx_s;
    logic rx_q;
    uaar_pkg::uaar_rx_st_type rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [9:0] rx_sh;
    logic [7:0] rx_buf;
    uaar_pkg::uaar_tx_st_type tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_idx;
    logic [10:0] tx_sh;
    logic txd;
    logic sclk;
  } uaar_top_st_type;

  uaar_top_st_type s_r;
  uaar_top_st_type s_nxt;

  logic [1:0] mode;
  logic nine_bit;
  logic [DIV_W-1:0] period;
  logic [DIV_W-1:0] reload;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_data;
  logic hit_baud;
  logic hit_id;
  logic hit_mask;
  logic hit_pwr;
  logic hit_any;
  logic wr_en;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] bcast;
  logic given_hit;
  logic bcast_hit;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // Mode and bit period
  // ---------------------------------------------------------------
  assign mode = s_r.ctrl[`UAAR_B_MHI:`UAAR_B_MLO];
  assign nine_bit = s_r.ctrl[`UAAR_B_MHI];

  always_comb begin
    unique case (mode)
      `UAAR_MODE_SHIFT: period = DIV_W'(`UAAR_M0_BIT);
      `UAAR_MODE_FIX9: period = s_r.baud_doubler ?
        DIV_W'(`UAAR_M2_DBL) : DIV_W'(`UAAR_M2_STD);
      default: period = s_r.baud_doubler ?
        {1'b0, s_r.baud[DIV_W-1:1]} : s_r.baud;
    endcase
    reload = (period == '0) ? '0 : period - 1'b1;
  end

  // ---------------------------------------------------------------
  // Address recognition
  // ---------------------------------------------------------------
  assign rx_byte = s_r.rx_sh[7:0];
  assign rx_ninth = s_r.rx_sh[8];
  assign bcast = s_r.slave_id | s_r.slave_mask;
  // Per-bit compare; cleared mask bits never block a given-address match
  assign given_hit =
    ((rx_byte ^ s_r.slave_id) & s_r.slave_mask) == 8'h00;
  assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = paddr == `UAAR_ADDR_CTRL;
  assign hit_data = paddr == `UAAR_ADDR_DATA;
  assign hit_baud = paddr == `UAAR_ADDR_BAUD;
  assign hit_id = paddr == `UAAR_ADDR_ID;
  assign hit_mask = paddr == `UAAR_ADDR_MASK;
  assign hit_pwr = paddr == `UAAR_ADDR_PWR;
  assign hit_any = hit_ctrl | hit_data | hit_baud | hit_id |
    hit_mask | hit_pwr;

  // Writes to a full transmit queue wait in the access phase
  assign pready = ~(access & pwrite & hit_data & ~fifo_in_ready);
  assign pslverr = access & ~hit_any;
  assign wr_en = access & pwrite & pready & hit_any;
  assign fifo_in_valid = access & pwrite & hit_data;
  assign prdata = s_r.rdata;
  assign fifo_out_ready = s_r.tx_st == uaar_pkg::TX_IDLE;
  assign txd = s_r.txd;
  assign shift_clk = s_r.sclk;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[7:0] = s_r.ctrl;
      rd_mux[`UAAR_B_MHI] = s_r.bit7_select ?
        s_r.fe : s_r.ctrl[`UAAR_B_MHI];
    end else if (hit_data) begin
      rd_mux[7:0] = s_r.rx_buf;
    end else if (hit_baud) begin
      rd_mux[DIV_W-1:0] = s_r.baud;
    end else if (hit_id) begin
      rd_mux[7:0] = s_r.slave_id;
    end else if (hit_mask) begin
      rd_mux[7:0] = s_r.slave_mask;
    end else if (hit_pwr) begin
      rd_mux[`UAAR_B_DBL] = s_r.baud_doubler;
      rd_mux[`UAAR_B_B7SEL] = s_r.bit7_select;
    end
  end

  // ---------------------------------------------------------------
  // Transmit queue
  // ---------------------------------------------------------------
  uaar_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_txq (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Read data is captured in the setup phase
    if (setup) begin
      s_nxt.rdata = rd_mux;
    end

    // Software writes first, hardware events below win
    if (wr_en && hit_ctrl) begin
      s_nxt.ctrl[6:0] = pwdata[6:0];
      if (s_r.bit7_select) begin
        s_nxt.fe = pwdata[7];
      end else begin
        s_nxt.ctrl[`UAAR_B_MHI] = pwdata[7];
      end
    end
    if (wr_en && hit_baud) begin
      s_nxt.baud = pwdata[DIV_W-1:0];
    end
    if (wr_en && hit_id) begin
      s_nxt.slave_id = pwdata[7:0];
    end
    if (wr_en && hit_mask) begin
      s_nxt.slave_mask = pwdata[7:0];
    end
    if (wr_en && hit_pwr) begin
      s_nxt.baud_doubler = pwdata[`UAAR_B_DBL];
      s_nxt.bit7_select = pwdata[`UAAR_B_B7SEL];
    end

    // Receive pin: three flops, level taken when the last two agree
    s_nxt.rx_s = {s_r.rx_s[1:0], rxd};
    if (s_r.rx_s[1] == s_r.rx_s[2]) begin
      s_nxt.rx_q = s_r.rx_s[2];
    end

    // -------------------------------------------------------------
    // Transmitter
    // -------------------------------------------------------------
    unique case (s_r.tx_st)
      uaar_pkg::TX_IDLE: begin
        s_nxt.txd = 1'b1;
        s_nxt.sclk = 1'b1;
        if (fifo_out_valid) begin
          s_nxt.tx_st = uaar_pkg::TX_SEND;
          s_nxt.tx_cnt = reload;
          if (mode == `UAAR_MODE_SHIFT) begin
            s_nxt.tx_sh = {3'h7, fifo_out_data};
            s_nxt.tx_idx = 4'h7;
          end else if (!nine_bit) begin
            s_nxt.tx_sh = {2'h3, fifo_out_data, 1'b0};
            s_nxt.tx_idx = 4'h9;
          end else begin
            s_nxt.tx_sh = {1'b1, s_r.ctrl[`UAAR_B_TB8],
              fifo_out_data, 1'b0};
            s_nxt.tx_idx = 4'hA;
          end
          s_nxt.txd = s_nxt.tx_sh[0];
          s_nxt.sclk = mode != `UAAR_MODE_SHIFT;
        end
      end
      uaar_pkg::TX_SEND: begin
        if (s_r.tx_cnt == '0) begin
          if (s_r.tx_idx == 4'h0) begin
            s_nxt.tx_st = uaar_pkg::TX_IDLE;
            s_nxt.txd = 1'b1;
            s_nxt.sclk = 1'b1;
            s_nxt.ctrl[`UAAR_B_TI] = 1'b1;
          end else begin
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
            s_nxt.txd = s_r.tx_sh[1];
            s_nxt.tx_idx = s_r.tx_idx - 1'b1;
            s_nxt.tx_cnt = reload;
            s_nxt.sclk = mode != `UAAR_MODE_SHIFT;
          end
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
          // Shift clock rises half way through each bit
          if (s_r.tx_cnt <= {1'b0, reload[DIV_W-1:1]}) begin
            s_nxt.sclk = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.tx_st = uaar_pkg::TX_IDLE;
      end
    endcase

    // -------------------------------------------------------------
    // Receiver
    // -------------------------------------------------------------
    unique case (s_r.rx_st)
      uaar_pkg::RX_IDLE: begin
        if (s_r.ctrl[`UAAR_B_REN] && mode != `UAAR_MODE_SHIFT &&
            !s_r.rx_q) begin
          s_nxt.rx_st = uaar_pkg::RX_START;
          s_nxt.rx_cnt = {1'b0, reload[DIV_W-1:1]};
        end
      end
      uaar_pkg::RX_START: begin
        if (s_r.rx_cnt != '0) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
        end else if (s_r.rx_q) begin
          // Glitch, not a start bit
          s_nxt.rx_st = uaar_pkg::RX_IDLE;
        end else begin
          s_nxt.rx_st = uaar_pkg::RX_DATA;
          s_nxt.rx_cnt = reload;
          s_nxt.rx_idx = 4'h0;
        end
      end
      uaar_pkg::RX_DATA: begin
        if (s_r.rx_cnt != '0) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 1'b1;
        end else if (s_r.rx_idx != (nine_bit ? 4'h9 : 4'h8)) begin
          s_nxt.rx_sh[s_r.rx_idx] = s_r.rx_q;
          s_nxt.rx_idx = s_r.rx_idx + 1'b1;
          s_nxt.rx_cnt = reload;
        end else begin
          // Stop bit sampled now
          s_nxt.rx_st = uaar_pkg::RX_IDLE;
          if (!s_r.rx_q) begin
            s_nxt.fe = 1'b1;
          end
          if (nine_bit) begin
            s_nxt.ctrl[`UAAR_B_RB8] = rx_ninth;
          end
          if (!s_r.ctrl[`UAAR_B_RI] &&
              (!s_r.ctrl[`UAAR_B_MPE] ||
               (nine_bit ? (rx_ninth && (given_hit || bcast_hit))
                         : s_r.rx_q))) begin
            s_nxt.rx_buf = rx_byte;
            s_nxt.ctrl[`UAAR_B_RI] = 1'b1;
            if (!nine_bit) begin
              s_nxt.ctrl[`UAAR_B_RB8] = s_r.rx_q;
            end
          end
        end
      end
      default: begin
        s_nxt.rx_st = uaar_pkg::RX_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= `UAAR_RST_CTRL;
      s_r.slave_id <= `UAAR_RST_ID;
      s_r.slave_mask <= `UAAR_RST_MASK;
      s_r.baud <= DIV_W'(`UAAR_RST_BAUD);
      s_r.rx_s <= 3'h7;
      s_r.rx_q <= 1'b1;
      s_r.rx_st <= uaar_pkg::RX_IDLE;
      s_r.tx_st <= uaar_pkg::TX_IDLE;
      s_r.txd <= 1'b1;
      s_r.sclk <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // uaar_top

// ===== uaar_monitor.sv
/*
  Checker of the serial port's register bus and pins.
  Assumes binding to uaar_top and sight of its ports only.
*/
`timescale 1ns/1ps
`include "uaar_cfg.svh"
module uaar_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial pins
  input wire logic rxd,
  input wire logic txd,
  input wire logic shift_clk
);
  logic [7:0] id_r, mask_r;
  logic [1:0] mode_r;
  logic sel7_r, dbl_r, acc, wr, rd, known;
  assign acc = psel && penable;
  assign wr = acc && pready && pwrite;
  assign rd = acc && !pwrite;
  assign known = paddr inside {`UAAR_ADDR_PWR, `UAAR_ADDR_CTRL,
    `UAAR_ADDR_DATA, `UAAR_ADDR_BAUD, `UAAR_ADDR_ID, `UAAR_ADDR_MASK};
  // Shadows of software-written fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_r <= 8'h00;
      mask_r <= 8'h00;
      mode_r <= 2'h0;
      {dbl_r, sel7_r} <= 2'h0;
    end else if (wr) begin
      if (paddr == `UAAR_ADDR_ID) id_r <= pwdata[7:0];
      if (paddr == `UAAR_ADDR_MASK) mask_r <= pwdata[7:0];
      if (paddr == `UAAR_ADDR_PWR) {dbl_r, sel7_r} <= pwdata[7:6];
      if (paddr == `UAAR_ADDR_CTRL) begin
        mode_r[0] <= pwdata[6];
        if (!sel7_r) mode_r[1] <= pwdata[7];
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  id_read_a: assert property (rd && paddr == `UAAR_ADDR_ID |->
    prdata == {24'h000000, id_r}) else $error("id readback wrong");
  mask_read_a: assert property (rd && paddr == `UAAR_ADDR_MASK |->
    prdata == {24'h000000, mask_r}) else $error("mask readback wrong");
  bad_addr_a: assert property (acc && !known |-> pslverr && pready &&
    prdata == 32'h00000000) else $error("unmapped access answered");
  err_cause_a: assert property (pslverr |-> acc && !known)
    else $error("error without cause");
  wait_cause_a: assert property (acc && !pready |-> pwrite &&
    paddr == `UAAR_ADDR_DATA) else $error("wait state without cause");
  rdata_hold_a: assert property (!(psel && !penable) |=>
    $stable(prdata)) else $error("read data moved");
  txd_reset_a: assert property ($rose(presetn) |-> txd && shift_clk)
    else $error("serial pins not idle");
  ctrl_mode_a: assert property (rd && paddr == `UAAR_ADDR_CTRL &&
    !sel7_r |-> prdata[7:6] == mode_r) else $error("mode bits wrong");
  shift_mode_a: assert property (!shift_clk |->
    mode_r == `UAAR_MODE_SHIFT) else $error("shift clock out of mode");
  m2_period_a: assert property ($fell(txd) &&
    mode_r == `UAAR_MODE_FIX9 && !dbl_r |-> ##63 !txd)
    else $error("fixed rate bit too short");
  cover property (wr && paddr == `UAAR_ADDR_DATA);
  cover property (acc && !pready);
  cover property (rd && paddr == `UAAR_ADDR_CTRL && prdata[0]);
endmodule // uaar_monitor

bind uaar_top uaar_monitor u_uaar_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .shift_clk(shift_clk));

// ===== uaar_far_end.sv
/*
  Far-end master of the serial line: sends frames on rxd and
  collects frames from txd, LSB first.
  Assumes the bench sets per, nine and listen before traffic.
*/
`timescale 1ns/1ps
module uaar_far_end (
  // Clock
  input wire logic pclk,
  // Serial line
  input wire logic txd,
  output logic rxd
);
  int per = 16;
  int cnt = 0;
  logic nine = 1'b1;
  logic listen = 1'b0;
  logic last_ninth = 1'b0;
  logic [7:0] last_byte = 8'h00;
  logic [7:0] sh;
  initial rxd = 1'b1;
  task automatic put(input logic v);
    rxd <= v;
    repeat (per) @(posedge pclk);
  endtask
  // Line idles high between frames
  task automatic send(input logic [7:0] b, input logic ninth,
      input logic stop_v);
    @(posedge pclk);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    if (nine) put(ninth);
    put(stop_v);
    rxd <= 1'b1;
  endtask
  initial forever begin
    @(negedge txd);
    if (listen) begin
      repeat (per / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (per) @(posedge pclk);
        sh[i] = txd;
      end
      if (nine) begin
        repeat (per) @(posedge pclk);
        last_ninth = txd;
      end
      repeat (per) @(posedge pclk);
      last_byte = sh;
      cnt++;
    end
  end
endmodule // uaar_far_end

// ===== tb_uart_slave_address_recognition.sv
/*
  Self-checking bench of the serial port with address recognition.
  Assumes the monitor binds itself and the far end is a model.
*/
`timescale 1ns/1ps
`include "uaar_cfg.svh"
module tb_uart_slave_address_recognition;
  logic pclk, presetn, psel, penable, pwrite, rxd, txd, shift_clk;
  logic pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int fails = 0;
  int checks_done = 0;
  int stalls = 0;
  uaar_top u_uaar_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .shift_clk(shift_clk));
  uaar_far_end u_uaar_far_end (.pclk(pclk), .txd(txd), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    logic rdy;
    int n;
    rdy = 1'b0;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (rdy !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      rdy = pready;
      rdata = prdata;
      err = pslverr;
      n++;
    end
    if (n > 1) stalls++;
    if (rdy !== 1'b1) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  function automatic logic hit(input logic [7:0] id, m, a);
    logic g, b;
    g = 1'b1;
    b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && a[i] != id[i]) g = 1'b0;
      if ((id[i] || m[i]) && !a[i]) b = 1'b0;
    end
    return g || b;
  endfunction
  task automatic wait_tx;
    int n;
    n = 0;
    rdata = 32'h00000000;
    while (rdata[1] !== 1'b1 && n < 400) begin
      rd(`UAAR_ADDR_CTRL);
      n++;
    end
    chk(32'(rdata[1]), 32'h00000001);
  endtask
  task automatic rx_frame(input logic [7:0] a, input logic ninth,
      input logic exp);
    u_uaar_far_end.send(a, ninth, 1'b1);
    repeat (8) @(posedge pclk);
    rd(`UAAR_ADDR_CTRL);
    chk(32'(rdata[0]), 32'(exp));
    chk(32'(rdata[2]), 32'(ninth));
    if (exp) begin
      rd(`UAAR_ADDR_DATA);
      chk(rdata, {24'h000000, a});
    end
    apb(1'b1, `UAAR_ADDR_CTRL, 32'h000000F0);
  endtask
  task automatic t_reset;
    rd(`UAAR_ADDR_ID);
    chk(rdata, 32'h00000000);
    rd(`UAAR_ADDR_MASK);
    chk(rdata, 32'h00000000);
    rd(12'h000);
    chk(32'(err), 32'h00000001);
    $display("t_reset done");
  endtask
  task automatic t_match;
    logic [7:0] ids [5] = '{8'h00, 8'hF1, 8'hF3, 8'hF2, 8'h56};
    logic [7:0] msk [5] = '{8'h00, 8'hFA, 8'hF9, 8'hFD, 8'hFF};
    logic [7:0] adr [7] = '{8'hF0, 8'hF3, 8'hF1, 8'hFF, 8'hFB, 8'h56,
      8'h57};
    apb(1'b1, `UAAR_ADDR_BAUD, 32'h00000010);
    apb(1'b1, `UAAR_ADDR_CTRL, 32'h000000F0);
    for (int s = 0; s < 5; s++) begin
      if (s > 0) begin
        apb(1'b1, `UAAR_ADDR_ID, {24'h000000, ids[s]});
        apb(1'b1, `UAAR_ADDR_MASK, {24'h000000, msk[s]});
      end
      for (int k = 0; k < 7; k++)
        rx_frame(adr[k], 1'b1, hit(ids[s], msk[s], adr[k]));
    end
    rx_frame(8'hFF, 1'b0, 1'b0);
    $display("t_match done");
  endtask
  task automatic t_framing;
    u_uaar_far_end.nine = 1'b0;
    apb(1'b1, `UAAR_ADDR_CTRL, 32'h00000050);
    apb(1'b1, `UAAR_ADDR_PWR, 32'h00000040);
    u_uaar_far_end.send(8'h5A, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    rd(`UAAR_ADDR_CTRL);
    chk(32'(rdata[7]), 32'h00000001);
    apb(1'b1, `UAAR_ADDR_CTRL, 32'h000000D0);
    u_uaar_far_end.send(8'hA5, 1'b0, 1'b1);
    repeat (8) @(posedge pclk);
    rd(`UAAR_ADDR_CTRL);
    chk(32'(rdata[7]), 32'h00000001);
    apb(1'b1, `UAAR_ADDR_CTRL, 32'h00000050);
    rd(`UAAR_ADDR_CTRL);
    chk(32'(rdata[7]), 32'h00000000);
    apb(1'b1, `UAAR_ADDR_PWR, 32'h00000000);
    rd(`UAAR_ADDR_CTRL);
    chk(32'(rdata[7:6]), 32'h00000001);
    $display("t_framing done");
  endtask
  task automatic t_tx;
    int c;
    u_uaar_far_end.nine = 1'b1;
    u_uaar_far_end.listen = 1'b1;
    apb(1'b1, `UAAR_ADDR_CTRL, 32'h000000C8);
    apb(1'b1, `UAAR_ADDR_DATA, 32'h000000A5);
    wait_tx;
    chk({24'h000000, u_uaar_far_end.last_byte}, 32'h000000A5);
    chk(32'(u_uaar_far_end.last_ninth), 32'h00000001);
    apb(1'b1, `UAAR_ADDR_BAUD, 32'h00000004);
    u_uaar_far_end.per = 4;
    c = u_uaar_far_end.cnt;
    stalls = 0;
    for (int i = 0; i < 20; i++) apb(1'b1, `UAAR_ADDR_DATA, 32'(i));
    chk(32'(stalls > 0), 32'h00000001);
    for (int n = 0; n < 2000 && u_uaar_far_end.cnt < c + 20; n++)
      @(posedge pclk);
    chk(32'(u_uaar_far_end.cnt - c), 32'h00000014);
    chk({24'h000000, u_uaar_far_end.last_byte}, 32'h00000013);
    $display("t_tx done");
  endtask
  task automatic t_modes;
    logic [1:0] mm;
    u_uaar_far_end.listen = 1'b0;
    for (int m = 0; m < 4; m++) begin
      mm = m[1:0];
      apb(1'b1, `UAAR_ADDR_CTRL, {24'h000000, mm, 6'h00});
      rd(`UAAR_ADDR_CTRL);
      chk(32'(rdata[7:6]), 32'(mm));
      apb(1'b1, `UAAR_ADDR_DATA, 32'h0000003C);
      wait_tx;
      apb(1'b1, `UAAR_ADDR_CTRL, {24'h000000, mm, 6'h00});
    end
    $display("t_modes done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_match;
    t_framing;
    t_tx;
    t_modes;
    results;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    results;
  end
endmodule // tb_uart_slave_address_recognition
